// ---- core/sadc_ctrl.sv ----
// Conversion start, busy and three-state read control of a 16-bit SAR converter.
// Assumes control pins are asynchronous to clk; the result bus is resolved outside.
module sadc_ctrl
(
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  select_n,
    input  wire logic                  conversion_trigger_n,
    input  wire logic                  read_n,
    input  wire sadc_pkg::sadc_word_s  sar_code,
    output logic                       busy,
    output logic [sadc_pkg::DATA_W-1:0] result_bus_o,
    output logic [sadc_pkg::DATA_W-1:0] result_bus_oe,
    output logic                       result_ready
);
    import sadc_pkg::*;

    sadc_ctrl_s  meta_r, sync_r;
    logic        trig_prev_r;
    sadc_state_e state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    sadc_word_s  latch_r, latch_nxt;
    logic        busy_r, busy_nxt;
    logic        oe_r, oe_nxt;
    logic        trig_fall;
    logic        fin_valid, fin_ready;
    logic        out_valid;
    sadc_word_s  out_word;

    // Two-flop synchroniser; only sync_r is read by logic
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            meta_r      <= '{select_n: 1'b1, trigger_n: 1'b1, read_n: 1'b1};
            sync_r      <= '{select_n: 1'b1, trigger_n: 1'b1, read_n: 1'b1};
            trig_prev_r <= 1'b1;
        end
        else
        begin
            meta_r      <= '{select_n: select_n, trigger_n: conversion_trigger_n,
                             read_n: read_n};
            sync_r      <= meta_r;
            trig_prev_r <= sync_r.trigger_n;
        end
    end

    // Start only on a falling trigger while selected; access alone does not start it
    assign trig_fall = trig_prev_r && !sync_r.trigger_n
                       && !sync_r.select_n;

    // Finished word waits in the buffer if the latch side stalls
    assign fin_valid = (state_r == SADC_DONE);

    // Conversion sequencer and busy
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        busy_nxt  = busy_r;
        unique case (state_r)
            SADC_IDLE:
            begin
                if (trig_fall)
                begin
                    state_nxt = SADC_CONV;
                    cnt_nxt   = '0;
                    busy_nxt  = 1'b0;
                end
            end
            SADC_CONV:
            begin
                // Further edges are not looked at here
                // Counter is shortened so pin edge to busy rise fits the limit
                if (cnt_r == CNT_W'(CONV_CYCLES - CONV_TAIL))
                begin
                    state_nxt = SADC_DONE;
                end
                else
                begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            SADC_DONE:
            begin
                // Busy stays low until the word is accepted
                if (fin_ready)
                begin
                    state_nxt = SADC_IDLE;
                end
            end
        endcase
        // Busy rises one cycle after the latch takes the new word
        if (state_r == SADC_IDLE && !trig_fall && !out_valid)
        begin
            busy_nxt = 1'b1;
        end
    end

    // Result latch, updated only by a finished conversion
    always_comb
    begin
        latch_nxt = latch_r;
        if (out_valid)
        begin
            latch_nxt = out_word;
        end
    end

    // Output enable; selected and read both low, otherwise float
    always_comb
    begin
        oe_nxt = !sync_r.select_n && !sync_r.read_n;
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_r <= SADC_IDLE;
            cnt_r   <= '0;
            busy_r  <= 1'b1;
            latch_r <= '{code: RESULT_RST};
            oe_r    <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            busy_r  <= busy_nxt;
            latch_r <= latch_nxt;
            oe_r    <= oe_nxt;
        end
    end

    // Buffer between conversion end and output latch
    sadc_buf2 u_buf
    (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (fin_valid),
        .in_ready  (fin_ready),
        .in_data   (sar_code),
        .out_valid (out_valid),
        .out_ready (1'b1),
        .out_data  (out_word)
    );

    // Pins; old result shows during a conversion, new before busy rises
    assign busy          = busy_r;
    assign result_bus_o  = latch_r.code;
    assign result_bus_oe = {DATA_W{oe_r}};
    assign result_ready  = out_valid;

endmodule // sadc_ctrl

// ---- inc/sadc_pkg.sv ----
// Package for the converter conversion and read control block.
// Assumes a 10 MHz core clock; all pin inputs arrive asynchronously.
package sadc_pkg;

    localparam int unsigned DATA_W        = 16;
    localparam int unsigned CLK_PERIOD_NS = 100;

    // Longest conversion duration, in nanoseconds
    localparam int unsigned CONV_MAX_NS   = 3800;
    // Longest time rounds down to whole cycles
    localparam int unsigned CONV_CYCLES   = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 6;
    // Cycles outside the counter: pin sync, done, buffer write, latch load, busy rise
    localparam int unsigned CONV_TAIL     = 7;

    // Trigger low time the controller should stay under, in nanoseconds
    localparam int unsigned TRIG_LOW_MAX_NS = 500;
    localparam int unsigned TRIG_LOW_CYCLES = TRIG_LOW_MAX_NS / CLK_PERIOD_NS;

    // Reset value of the output latches
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // Successive-approximation states
    typedef enum logic [1:0] {
        SADC_IDLE,
        SADC_CONV,
        SADC_DONE
    } sadc_state_e;

    // Synchronised control pins
    typedef struct packed {
        logic select_n;
        logic trigger_n;
        logic read_n;
    } sadc_ctrl_s;

    // Result word with its two's complement code
    typedef struct packed {
        logic [15:0] code;
    } sadc_word_s;

endpackage

// ---- core/sadc_buf2.sv ----
// Two-entry buffer carrying completed conversion results.
// Assumes the same clock and synchronous active-low reset as its user.
module sadc_buf2
    import sadc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire sadc_word_s  in_data,
    output logic             out_valid,
    input  wire logic        out_ready,
    output sadc_word_s       out_data
);
    import sadc_pkg::*;

    sadc_word_s mem_r [2];
    sadc_word_s mem_nxt [2];
    logic       wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic       push, pop;

    // Handshakes; ready drops only when both entries hold words
    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next pointers, count and storage
    always_comb
    begin
        mem_nxt = mem_r;
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (push)
        begin
            mem_nxt[wp_r] = in_data;
            wp_nxt        = ~wp_r;
        end
        if (pop)
        begin
            rp_nxt = ~rp_r;
        end
        if (push && !pop)
        begin
            cnt_nxt = cnt_r + 2'h1;
        end
        else if (pop && !push)
        begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    // Register stage
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            mem_r[0] <= '{code: RESULT_RST};
            mem_r[1] <= '{code: RESULT_RST};
            wp_r     <= 1'b0;
            rp_r     <= 1'b0;
            cnt_r    <= 2'h0;
        end
        else
        begin
            mem_r <= mem_nxt;
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule // sadc_buf2

// ---- bench/sadc_ctrl_properties.sv ----
// Checker for the conversion start, busy and read control block.
// Assumes binding to sadc_ctrl; pins reach the logic through a 3-cycle lag.
module sadc_ctrl_chk
(
    input wire logic                        clk,
    input wire logic                        rstn,
    input wire logic                        select_n,
    input wire logic                        conversion_trigger_n,
    input wire logic                        read_n,
    input wire logic                        busy,
    input wire logic [sadc_pkg::DATA_W-1:0] result_bus_o,
    input wire logic [sadc_pkg::DATA_W-1:0] result_bus_oe,
    input wire logic                        result_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Select must be low long enough to pass the synchroniser
    start_sel_a: assert property (
        (!select_n)[*4] ##0 (busy && $fell(conversion_trigger_n)) |-> ##[1:5] !busy)
        else $error("trigger edge did not start a conversion");
    busy_low_a: assert property (
        $fell(busy) |-> (!busy)[*8] ##1 (!busy)[*8] ##1 (!busy)[*8] ##1 (!busy)[*8])
        else $error("busy rose too early");
    // A restart would stretch busy past the upper bound
    busy_end_a: assert property (
        $fell(busy) |-> ##[34:35] $rose(busy)) else $error("conversion length wrong");
    new_first_a: assert property (
        $rose(busy) |-> $past(result_ready) || $past(result_ready, 2) || $past(result_ready, 3))
        else $error("busy rose before new result");
    latch_hold_a: assert property (
        $changed(result_bus_o) |-> $past(result_ready) || $past(result_ready, 2))
        else $error("result changed without new conversion");
    oe_off_a: assert property (
        (select_n || read_n)[*5] |-> result_bus_oe == 16'h0000)
        else $error("outputs driven without read");
    oe_on_a: assert property (
        (!select_n && !read_n)[*5] |-> result_bus_oe == 16'hFFFF)
        else $error("outputs not driven during read");
    idle_sel_a: assert property (
        select_n[*6] |-> !$fell(busy)) else $error("conversion started while deselected");
    oe_all_a: assert property (
        result_bus_oe == 16'h0000 || result_bus_oe == 16'hFFFF)
        else $error("partial output enable");

    cover property ($rose(busy));
    cover property ((!select_n && !read_n)[*5]);
    cover property (busy && $fell(conversion_trigger_n) && !read_n);
endmodule // sadc_ctrl_chk

// ---- bench/sadc_bus_model.sv ----
// Processor-side data bus model that resolves the three-state result lines.
// Assumes no pull resistors on the bus.
module sadc_bus_model
(
    input  wire logic [15:0] drv,
    input  wire logic [15:0] oe,
    output logic      [15:0] bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] last_r = 16'h0000;

    // Released bits show the inverse so a stale read cannot pass
    always @(drv or oe)
        foreach (oe[i])
            if (oe[i])
                last_r[i] = drv[i];
    assign bus = (drv & oe) | (~last_r & ~oe);
endmodule // sadc_bus_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the conversion start, busy and read control block.
// Assumes sadc_pkg first; processor pins change on falling clock edges.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sadc_pkg::*;
    logic        clk, rstn, sel_n, trig_n, rd_n, busy, rdy;
    sadc_word_s  code;
    logic [15:0] res_o, res_oe, dbus;
    int          n_fail, total_checks;

    sadc_ctrl u_dut (.clk(clk), .rstn(rstn), .select_n(sel_n), .conversion_trigger_n(trig_n),
        .read_n(rd_n), .sar_code(code), .busy(busy), .result_bus_o(res_o),
        .result_bus_oe(res_oe), .result_ready(rdy));
    sadc_bus_model u_bus (.drv(res_o), .oe(res_oe), .bus(dbus));

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Bounded wait; a timeout shows as a busy mismatch
    task automatic wait_busy(input logic v);
        for (int k = 0; k < 60 && busy !== v; k++)
            cyc(1);
        chk({15'h0000, v}, {15'h0000, busy});
    endtask
    task automatic pulse(input int n, input logic rd_too);
        trig_n = 1'b0;
        rd_n = rd_too ? 1'b0 : rd_n;
        cyc(n);
        trig_n = 1'b1;
        rd_n = rd_too ? 1'b1 : rd_n;
    endtask
    task automatic t_mode1();
        sel_n = 1'b0;
        rd_n = 1'b0;
        code = 16'h8001;
        pulse(2, 1'b0);
        wait_busy(1'b0);
        cyc(10);
        pulse(2, 1'b0);
        wait_busy(1'b1);
        chk(16'h8001, dbus);
        cyc(8);
        chk(16'h0001, {15'h0000, busy});
        rd_n = 1'b1;
    endtask
    task automatic t_mode2();
        code = 16'h1234;
        pulse(2, 1'b0);
        wait_busy(1'b0);
        wait_busy(1'b1);
        chk(16'h0000, {15'h0000, rdy});
        cyc(4);
        chk(16'h0000, res_oe);
        rd_n = 1'b0;
        cyc(4);
        chk(16'h1234, dbus);
        rd_n = 1'b1;
        code = 16'h0F0F;
        cyc(6);
        chk(16'h0000, res_oe);
        chk(16'h1234, res_o);
    endtask
    task automatic t_desel();
        sel_n = 1'b1;
        rd_n = 1'b0;
        pulse(2, 1'b0);
        cyc(8);
        chk(16'h0001, {15'h0000, busy});
        chk(16'h0000, res_oe);
        rd_n = 1'b1;
        sel_n = 1'b0;
        cyc(6);
    endtask
    task automatic t_combined();
        code = 16'h5A5A;
        trig_n = 1'b0;
        rd_n = 1'b0;
        wait_busy(1'b0);
        cyc(2);
        chk(16'h1234, dbus);
        wait_busy(1'b1);
        chk(16'h5A5A, dbus);
        trig_n = 1'b1;
        rd_n = 1'b1;
        code = 16'hA5A5;
        cyc(3);
        pulse(4, 1'b1);
        chk(16'h5A5A, dbus);
        wait_busy(1'b0);
        wait_busy(1'b1);
        pulse(4, 1'b1);
        chk(16'hA5A5, dbus);
        wait_busy(1'b0);
        wait_busy(1'b1);
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // About 240 cycles of work; 3000 means a hang
    initial
    begin
        #300000;
        n_fail++;
        end_of_test();
    end
    initial
    begin
        rstn = 1'b0;
        sel_n = 1'b1;
        trig_n = 1'b1;
        rd_n = 1'b1;
        code = 16'h0000;
        cyc(2);
        chk(16'h0000, res_oe);
        chk(16'h0000, res_o);
        rstn = 1'b1;
        cyc(3);
        t_mode1();
        t_mode2();
        t_desel();
        t_combined();
        end_of_test();
    end
endmodule // tb_top

bind sadc_ctrl sadc_ctrl_chk u_chk (.clk(clk), .rstn(rstn), .select_n(select_n),
    .conversion_trigger_n(conversion_trigger_n), .read_n(read_n), .busy(busy),
    .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe), .result_ready(result_ready));
